// ### logic/sysmsr_pkg.sv
// package: model-register address, field positions and encodings for the system configuration block
package sysmsr_pkg;

    // ********************************************************************
    // register address and layout
    // ********************************************************************
    localparam logic [31:0] SYSTEM_CONFIGURATION_ADDR = 32'hc001_0010;
    localparam int          FIX_DRAM_EN_BIT           = 18;
    localparam int          FIX_MOD_EN_BIT            = 19;
    localparam int          VAR_RANGE_EN_BIT          = 20;
    localparam int          SECOND_TOP_EN_BIT         = 21;
    localparam int          FORCE_WB_BIT              = 22;
    // defined bits 22:18 are writable; all others reserved
    localparam logic [63:0] SYS_CONFIG_WRITE_MASK     = 64'h0000_0000_007c_0000;
    localparam logic [63:0] SYS_CONFIG_RESET          = 64'h0000_0000_0000_0000;

    // ********************************************************************
    // memory types and fixed-range attribute positions
    // ********************************************************************
    localparam logic [2:0]  MEM_TYPE_WB               = 3'h6;
    localparam int          ATTR_WRITE_TO_DRAM_BIT    = 3;
    localparam int          ATTR_READ_TO_DRAM_BIT     = 4;
    // 4GB boundary on a 52-bit physical address
    localparam logic [51:0] FOUR_GB                   = 52'h0_0001_0000_0000;

endpackage : sysmsr_pkg

// ### logic/sysmsr_block.sv
// design: system configuration model register and the memory-typing gates it controls
// Functional notes
// - fixed-range dram attributes honoured only when enabled
// - modify enable off: attribute writes dropped, reads zero
// - variable enable activates low top and io ranges
// - second-top enable activates upper top-of-memory
// - force write-back default between 4GB and top
// - forced default needs default enable; overridable
// - privileged model-register access only; defined bits rw
`timescale 1ns/1ps
`default_nettype none

module sysmsr_block (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    // model-register access port
    input  wire logic        msr_wr_i,
    input  wire logic        msr_rd_i,
    input  wire logic        msr_priv_i,
    input  wire logic [31:0] msr_addr_i,
    input  wire logic [63:0] msr_wdata_i,
    output logic      [63:0] msr_rdata_o,
    output logic             msr_hit_o,
    output logic             msr_fault_o,
    // fixed-range attribute path (one 8-bit type field)
    input  wire logic [7:0]  fix_attr_stored_i,
    input  wire logic [7:0]  fix_attr_wdata_i,
    output logic      [7:0]  fix_attr_wdata_o,
    output logic      [7:0]  fix_attr_rdata_o,
    output logic             fix_read_to_dram_o,
    output logic             fix_write_to_dram_o,
    // memory-type resolution
    input  wire logic [51:0] phys_addr_i,
    input  wire logic [51:0] top_of_memory_high_i,
    input  wire logic        default_type_enable_i,
    input  wire logic [2:0]  default_mem_type_i,
    input  wire logic        range_override_i,
    input  wire logic [2:0]  range_mem_type_i,
    output logic      [2:0]  mem_type_o,
    // register activation
    output logic             top_of_memory_low_active_o,
    output logic             io_range_register_active_o,
    output logic             top_of_memory_high_active_o
);

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic [63:0] system_configuration;
        logic [63:0] rdata;
        logic        hit;
        logic        fault;
    } sysmsr_state_t;

    sysmsr_state_t st_r;
    sysmsr_state_t st_nxt;

    logic sel;
    logic in_upper;

    assign sel = (msr_addr_i == sysmsr_pkg::SYSTEM_CONFIGURATION_ADDR);

    // ********************************************************************
    // register access
    // ********************************************************************
    always_comb begin
        st_nxt       = st_r;
        st_nxt.hit   = 1'b0;
        st_nxt.fault = 1'b0;
        if ((msr_wr_i || msr_rd_i) && sel) begin
            st_nxt.hit = 1'b1;
            // unprivileged access is refused and leaves state alone
            if (!msr_priv_i) begin
                st_nxt.fault = 1'b1;
            end else if (msr_wr_i) begin
                st_nxt.system_configuration = msr_wdata_i & sysmsr_pkg::SYS_CONFIG_WRITE_MASK;
            end else begin
                st_nxt.rdata = st_r.system_configuration;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            st_r <= '{system_configuration: sysmsr_pkg::SYS_CONFIG_RESET,
                      rdata: 64'h0, hit: 1'b0, fault: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign msr_rdata_o = st_r.rdata;
    assign msr_hit_o   = st_r.hit;
    assign msr_fault_o = st_r.fault;

    // ********************************************************************
    // fixed-range attribute gating
    // ********************************************************************
    localparam logic [7:0] ATTR_MASK = 8'h18;
    logic fix_en;
    logic mod_en;
    assign fix_en = st_r.system_configuration[sysmsr_pkg::FIX_DRAM_EN_BIT];
    assign mod_en = st_r.system_configuration[sysmsr_pkg::FIX_MOD_EN_BIT];

    always_comb begin
        if (mod_en) begin
            fix_attr_wdata_o = fix_attr_wdata_i;
            fix_attr_rdata_o = fix_attr_stored_i;
        end else begin
            // keep stored dram bits, take new type bits
            fix_attr_wdata_o = (fix_attr_wdata_i & ~ATTR_MASK)
                             | (fix_attr_stored_i & ATTR_MASK);
            fix_attr_rdata_o = fix_attr_stored_i & ~ATTR_MASK;
        end
    end

    assign fix_read_to_dram_o  = fix_en
                               && fix_attr_stored_i[sysmsr_pkg::ATTR_READ_TO_DRAM_BIT];
    assign fix_write_to_dram_o = fix_en
                               && fix_attr_stored_i[sysmsr_pkg::ATTR_WRITE_TO_DRAM_BIT];

    // ********************************************************************
    // activation and default type
    // ********************************************************************
    assign top_of_memory_low_active_o  = st_r.system_configuration[sysmsr_pkg::VAR_RANGE_EN_BIT];
    assign io_range_register_active_o  = st_r.system_configuration[sysmsr_pkg::VAR_RANGE_EN_BIT];
    assign top_of_memory_high_active_o = st_r.system_configuration[sysmsr_pkg::SECOND_TOP_EN_BIT];

    assign in_upper = (phys_addr_i >= sysmsr_pkg::FOUR_GB) && (phys_addr_i < top_of_memory_high_i);

    // range registers win over any default; the page table is applied downstream
    always_comb begin
        if (range_override_i) begin
            mem_type_o = range_mem_type_i;
        end else if (default_type_enable_i && in_upper
                     && st_r.system_configuration[sysmsr_pkg::FORCE_WB_BIT]) begin
            mem_type_o = sysmsr_pkg::MEM_TYPE_WB;
        end else begin
            mem_type_o = default_mem_type_i;
        end
    end

endmodule : sysmsr_block
`default_nettype wire

// ### dv/sysmsr_chk.sv
// checker: port-level assertions for the system configuration block
`timescale 1ns/1ps
`default_nettype none
module sysmsr_chk (
    input wire logic        clk_sys_i, rstn_i, msr_wr_i, msr_rd_i, msr_priv_i, msr_hit_o,
    input wire logic        msr_fault_o, fix_read_to_dram_o, fix_write_to_dram_o,
    input wire logic        default_type_enable_i, range_override_i,
    input wire logic        top_of_memory_low_active_o, io_range_register_active_o,
    input wire logic        top_of_memory_high_active_o,
    input wire logic [31:0] msr_addr_i,
    input wire logic [63:0] msr_wdata_i, msr_rdata_o,
    input wire logic [7:0]  fix_attr_stored_i, fix_attr_wdata_o, fix_attr_rdata_o,
    input wire logic [51:0] phys_addr_i, top_of_memory_high_i,
    input wire logic [2:0]  range_mem_type_i, mem_type_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    wire sel = msr_addr_i == sysmsr_pkg::SYSTEM_CONFIGURATION_ADDR;
    wire wok = msr_wr_i && msr_priv_i && sel;
    // upper region is exclusive of the top boundary
    wire up  = phys_addr_i >= sysmsr_pkg::FOUR_GB && phys_addr_i < top_of_memory_high_i;
    a_fix_attr_off: assert property ($past(wok && !msr_wdata_i[18]) |->
        !fix_read_to_dram_o && !fix_write_to_dram_o) else $error("dram attribute leaks");
    a_mod_lock: assert property ($past(wok && !msr_wdata_i[19]) |-> fix_attr_rdata_o[4:3] == 2'h0
        && fix_attr_wdata_o[4:3] == fix_attr_stored_i[4:3]) else $error("attribute not locked");
    a_var_active: assert property ($past(wok) |-> top_of_memory_low_active_o ==
        $past(msr_wdata_i[20]) && io_range_register_active_o == top_of_memory_low_active_o)
        else $error("variable range activation wrong");
    a_top_active: assert property ($past(wok) |->
        top_of_memory_high_active_o == $past(msr_wdata_i[21])) else $error("upper top wrong");
    a_force_wb: assert property ($past(wok && msr_wdata_i[22]) && default_type_enable_i
        && !range_override_i && up |-> mem_type_o == sysmsr_pkg::MEM_TYPE_WB) else $error("no wb");
    a_range_wins: assert property (range_override_i |-> mem_type_o == range_mem_type_i)
        else $error("range override lost");
    a_unpriv_fault: assert property ((msr_wr_i || msr_rd_i) && sel && !msr_priv_i |=>
        msr_fault_o && msr_hit_o) else $error("unprivileged access not refused");
    a_no_hit: assert property (!(msr_wr_i || msr_rd_i) || !sel |=> !msr_hit_o && !msr_fault_o)
        else $error("hit without access");
    a_rsvd_zero: assert property (msr_hit_o |->
        (msr_rdata_o & ~sysmsr_pkg::SYS_CONFIG_WRITE_MASK) == 64'h0) else $error("reserved bits set");
endmodule : sysmsr_chk
bind sysmsr_block sysmsr_chk u_sysmsr_chk (.*);
`default_nettype wire

// ### dv/test_sysmsr_block.sv
// testbench: directed scenarios for the system configuration block
`timescale 1ns/1ps
`default_nettype none
module test_sysmsr_block;
    logic        clk_sys_i = 1'b0, rstn_i = 1'b0, msr_wr_i = 1'b0, msr_rd_i = 1'b0;
    logic        msr_priv_i = 1'b1, default_type_enable_i = 1'b1, range_override_i = 1'b0;
    logic [31:0] msr_addr_i = sysmsr_pkg::SYSTEM_CONFIGURATION_ADDR;
    logic [63:0] msr_wdata_i = 64'h0;
    logic [7:0]  fix_attr_stored_i = 8'h18, fix_attr_wdata_i = 8'h06;
    logic [51:0] phys_addr_i = 52'h0, top_of_memory_high_i = 52'h2_0000_0000;
    logic [2:0]  default_mem_type_i = 3'h0, range_mem_type_i = 3'h1;
    wire  [63:0] msr_rdata_o;
    wire  [7:0]  fix_attr_wdata_o, fix_attr_rdata_o;
    wire  [2:0]  mem_type_o;
    wire         msr_hit_o, msr_fault_o, fix_read_to_dram_o, fix_write_to_dram_o;
    wire         top_of_memory_low_active_o, io_range_register_active_o;
    wire         top_of_memory_high_active_o;
    wire  [2:0]  act = {top_of_memory_low_active_o, io_range_register_active_o,
                        top_of_memory_high_active_o};
    int          n_fail = 0, n_tests = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    sysmsr_block u_sysmsr_block (.*);
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one access; returns in the cycle where hit and read data stand
    task automatic acc(input logic wr, input logic [63:0] d);
        @(posedge clk_sys_i) #1;
        {msr_wr_i, msr_rd_i, msr_wdata_i} = {wr, !wr, d};
        @(posedge clk_sys_i) #1;
        {msr_wr_i, msr_rd_i} = 2'b00;
    endtask : acc
    task automatic s_unpriv;
        msr_priv_i = 1'b0;
        acc(1'b1, 64'hffff_ffff_ffff_ffff);
        chk({msr_hit_o, msr_fault_o}, 2'h3);
        msr_priv_i = 1'b1;
        acc(1'b0, 64'h0);
        chk(msr_rdata_o, 64'h0);
        msr_addr_i = 32'hc001_0011;
        acc(1'b0, 64'h0);
        chk(msr_hit_o, 1'b0);
        msr_addr_i = sysmsr_pkg::SYSTEM_CONFIGURATION_ADDR;
    endtask : s_unpriv
    task automatic s_full;
        acc(1'b1, 64'hffff_ffff_ffff_ffff);
        chk(act, 3'h7);
        chk({fix_read_to_dram_o, fix_write_to_dram_o, fix_attr_rdata_o}, {2'h3, 8'h18});
        chk(fix_attr_wdata_o, 8'h06);
        acc(1'b0, 64'h0);
        chk(msr_rdata_o, sysmsr_pkg::SYS_CONFIG_WRITE_MASK);
    endtask : s_full
    task automatic s_clear;
        acc(1'b1, 64'h0);
        chk({fix_read_to_dram_o, fix_write_to_dram_o, fix_attr_rdata_o}, 10'h0);
        chk(fix_attr_wdata_o, 8'h1e);
        chk(act, 3'h0);
    endtask : s_clear
    task automatic s_wb;
        acc(1'b1, 64'h40_0000);
        phys_addr_i = sysmsr_pkg::FOUR_GB;
        @(posedge clk_sys_i) #1;
        chk(mem_type_o, sysmsr_pkg::MEM_TYPE_WB);
        phys_addr_i = top_of_memory_high_i;
        @(posedge clk_sys_i) #1;
        chk(mem_type_o, 3'h0);
        {phys_addr_i, default_type_enable_i} = {sysmsr_pkg::FOUR_GB, 1'b0};
        @(posedge clk_sys_i) #1;
        chk(mem_type_o == sysmsr_pkg::MEM_TYPE_WB, 1'b0);
        {default_type_enable_i, range_override_i} = 2'b11;
        @(posedge clk_sys_i) #1;
        chk(mem_type_o, 3'h1);
    endtask : s_wb
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1 rstn_i = 1'b1;
        s_unpriv;
        s_full;
        s_clear;
        s_wb;
        end_of_test;
    end
    initial begin
        #20000;
        n_fail++;
        end_of_test;
    end
endmodule : test_sysmsr_block
`default_nettype wire
